// ---- include/rits_pkg.sv ----
`default_nettype none
package rits_pkg;
  localparam int unsigned CLK_PERIOD_NS    = 50;
  // Longest wait for a stamp before the packet is forwarded unstamped.
  localparam int unsigned STAMP_WAIT_NS    = 10000;
  localparam int unsigned STAMP_WAIT_CYCLES = (STAMP_WAIT_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                              (STAMP_WAIT_NS / CLK_PERIOD_NS);
  localparam int unsigned STAMP_LAT_CYCLES = 2;
  localparam int unsigned WAIT_CNT_W       = 16;
  localparam int unsigned TIME_W           = 32;
  localparam int unsigned DATA_W           = 32;
  localparam int unsigned EVT_DEPTH        = 4;
  localparam int unsigned WORD_IDX_W       = 3;
  localparam logic [WORD_IDX_W-1:0] ETYPE_WORD_IDX = 3'h3;
  localparam int unsigned ETYPE_LSB        = 16;
  localparam int unsigned ETYPE_W          = 16;

  typedef enum logic [1:0] {
    RITS_IDLE = 2'h0,
    RITS_WAIT = 2'h1,
    RITS_PASS = 2'h2
  } rits_state_t;
endpackage : rits_pkg
`default_nettype wire

// ---- include/rits_ts_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface rits_ts_if;
  logic                        req;
  logic [rits_pkg::TIME_W-1:0] time_now;
  logic                        stamp_valid;
  logic [rits_pkg::TIME_W-1:0] stamp;

  modport unit (input req, output time_now, output stamp_valid, output stamp);
  modport port (output req, input time_now, input stamp_valid, input stamp);
endinterface : rits_ts_if
`default_nettype wire

// ---- logic/rits_time_sync_unit.sv ----
`timescale 1ns/10ps
`default_nettype none
module rits_time_sync_unit #(
  parameter int unsigned LAT = rits_pkg::STAMP_LAT_CYCLES
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // Stamp service
  rits_ts_if.unit  ts
);
  logic [rits_pkg::TIME_W-1:0] time_cnt;
  logic [LAT-1:0]              req_line;
  logic [rits_pkg::TIME_W-1:0] stamp_line [LAT];

  assign ts.time_now    = time_cnt;
  // A stamp exists only for a request that was issued.
  assign ts.stamp_valid = req_line[LAT-1];
  assign ts.stamp       = stamp_line[LAT-1];

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      time_cnt <= '0;
      req_line <= '0;
      for (int i = 0; i < LAT; i++) begin
        stamp_line[i] <= '0;
      end
    end else begin
      time_cnt      <= time_cnt + 1'b1;
      req_line[0]   <= ts.req;
      stamp_line[0] <= time_cnt;
      for (int i = 1; i < LAT; i++) begin
        req_line[i]   <= req_line[i-1];
        stamp_line[i] <= stamp_line[i-1];
      end
    end
  end
endmodule : rits_time_sync_unit
`default_nettype wire

// ---- logic/rits_rx_ingress_ts.sv ----
// Contract
// - Event mode records a stamp when a packet carries the chosen EtherType.
// - Host-timestamp mode stamps every received packet with a clean preamble, not only PTP ones.
// - Host-timestamp mode delivers each stamp alongside its packet on the DMA path.
// - With host-timestamp mode on, each packet waits for a stamp before proceeding.
// - A corrupted preamble means no stamp request is issued for that packet.
// - A missing request yields no stamp; after the wait bound the packet goes to the host unstamped.
// - Clearing the host-stamp enable turns the mode off, so start words pass without the stamp wait.
`timescale 1ns/10ps
`default_nettype none
module rits_rx_ingress_ts #(
  parameter int unsigned WAIT_CYCLES = rits_pkg::STAMP_WAIT_CYCLES,
  parameter int unsigned EVT_DEPTH   = rits_pkg::EVT_DEPTH
) (
  // Clock and reset
  input  wire logic                           clock_in,
  input  wire logic                           rst_b_in,
  // Time-sync control bits
  input  wire logic                           host_stamp_en_in,
  input  wire logic                           evt_en_in,
  input  wire logic [rits_pkg::ETYPE_W-1:0]   evt_ethertype_in,
  // Ingress from the switch ports
  input  wire logic                           pkt_valid_in,
  input  wire logic                           pkt_sop_in,
  input  wire logic                           pkt_eop_in,
  input  wire logic [rits_pkg::DATA_W-1:0]    pkt_data_in,
  input  wire logic                           pkt_preamble_ok_in,
  output var  logic                           pkt_ready_out,
  // Host DMA path
  output var  logic                           dma_valid_out,
  output var  logic                           dma_sop_out,
  output var  logic                           dma_eop_out,
  output var  logic [rits_pkg::DATA_W-1:0]    dma_data_out,
  output var  logic [rits_pkg::TIME_W-1:0]    dma_stamp_out,
  output var  logic                           dma_stamp_ok_out,
  input  wire logic                           dma_ready_in,
  // Event stamp queue
  output var  logic                           evt_valid_out,
  output var  logic [rits_pkg::TIME_W-1:0]    evt_stamp_out,
  input  wire logic                           evt_pop_in,
  output var  logic                           evt_overflow_out
);
  localparam int unsigned PTR_W = $clog2(EVT_DEPTH);
  localparam logic [rits_pkg::WAIT_CNT_W-1:0] WAIT_LAST =
    rits_pkg::WAIT_CNT_W'(WAIT_CYCLES - 1);
  localparam logic [PTR_W:0] EVT_FULL = (PTR_W+1)'(EVT_DEPTH);

  rits_ts_if ts ();

  rits_time_sync_unit u_time_sync (
    .clock_in (clock_in),
    .rst_b_in (rst_b_in),
    .ts       (ts.unit)
  );

  rits_pkg::rits_state_t state;
  rits_pkg::rits_state_t next_state;

  logic [rits_pkg::DATA_W-1:0]     hold_data;
  logic                            hold_eop;
  logic                            stamp_got;
  logic [rits_pkg::TIME_W-1:0]     stamp_hold;
  logic [rits_pkg::WAIT_CNT_W-1:0] wait_cnt;
  logic [rits_pkg::WORD_IDX_W-1:0] word_idx;
  logic [rits_pkg::TIME_W-1:0]     sop_time;
  logic [rits_pkg::TIME_W-1:0]     evt_mem [EVT_DEPTH];
  logic [PTR_W-1:0]                wr_ptr;
  logic [PTR_W-1:0]                rd_ptr;
  logic [PTR_W:0]                  evt_count;

  // Ingress acceptance and stamp request.
  wire accept    = pkt_valid_in & pkt_ready_out;
  wire sop_take  = accept & pkt_sop_in;
  wire out_free  = ~dma_valid_out | dma_ready_in;
  // Only a packet with a clean preamble asks for a stamp.
  assign ts.req  = sop_take & pkt_preamble_ok_in & host_stamp_en_in;

  // Waiting ends on a stamp or on the bound, never on nothing.
  wire timed_out  = (wait_cnt == WAIT_LAST);
  wire stamp_now  = ts.stamp_valid & (state == rits_pkg::RITS_WAIT);
  wire have_stamp = stamp_got | stamp_now;
  wire wait_done  = (state == rits_pkg::RITS_WAIT) & (have_stamp | timed_out) & out_free;
  wire [rits_pkg::TIME_W-1:0] stamp_sel = stamp_got ? stamp_hold : ts.stamp;

  // Word position within the packet, used to find the EtherType.
  wire [rits_pkg::WORD_IDX_W-1:0] cur_idx = pkt_sop_in ? '0 : word_idx;
  wire [rits_pkg::ETYPE_W-1:0] etype_field =
    pkt_data_in[rits_pkg::ETYPE_LSB +: rits_pkg::ETYPE_W];
  wire [rits_pkg::TIME_W-1:0] evt_time = pkt_sop_in ? ts.time_now : sop_time;
  wire etype_hit = accept & evt_en_in & (cur_idx == rits_pkg::ETYPE_WORD_IDX) &
                   (etype_field == evt_ethertype_in);

  // Event queue bookkeeping.
  wire evt_pop   = evt_pop_in & evt_valid_out;
  wire evt_full  = (evt_count == EVT_FULL);
  wire evt_push  = etype_hit & (~evt_full | evt_pop);
  wire evt_drop  = etype_hit & evt_full & ~evt_pop;
  wire [PTR_W-1:0] next_rd_ptr = evt_pop ? PTR_W'(rd_ptr + 1'b1) : rd_ptr;
  wire [PTR_W:0] next_evt_count = evt_count + (PTR_W+1)'(evt_push) - (PTR_W+1)'(evt_pop);
  wire [rits_pkg::TIME_W-1:0] next_evt_head =
    (evt_push & (next_rd_ptr == wr_ptr)) ? evt_time : evt_mem[next_rd_ptr];

  // Loads into the DMA output register.
  wire load_direct = accept & (state != rits_pkg::RITS_WAIT) &
                     ~(pkt_sop_in & host_stamp_en_in);
  wire load_out    = load_direct | wait_done;
  wire next_out_valid = load_out | (dma_valid_out & ~dma_ready_in);

  always_comb begin
    next_state = state;
    unique case (state)
      rits_pkg::RITS_IDLE: begin
        if (sop_take && host_stamp_en_in) begin
          next_state = rits_pkg::RITS_WAIT;
        end else if (sop_take && !pkt_eop_in) begin
          next_state = rits_pkg::RITS_PASS;
        end
      end
      rits_pkg::RITS_WAIT: begin
        if (wait_done) begin
          next_state = hold_eop ? rits_pkg::RITS_IDLE : rits_pkg::RITS_PASS;
        end
      end
      rits_pkg::RITS_PASS: begin
        // A start word cut into an unfinished packet still needs its stamp.
        if (sop_take && host_stamp_en_in) begin
          next_state = rits_pkg::RITS_WAIT;
        end else if (accept && pkt_eop_in) begin
          next_state = rits_pkg::RITS_IDLE;
        end
      end
      default: begin
        next_state = rits_pkg::RITS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state         <= rits_pkg::RITS_IDLE;
      pkt_ready_out <= 1'b0;
      dma_valid_out <= 1'b0;
    end else begin
      state         <= next_state;
      // Ready only when the output register will be empty; costs half rate.
      pkt_ready_out <= (next_state != rits_pkg::RITS_WAIT) & ~next_out_valid;
      dma_valid_out <= next_out_valid;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dma_sop_out      <= 1'b0;
      dma_eop_out      <= 1'b0;
      dma_data_out     <= '0;
      dma_stamp_out    <= '0;
      dma_stamp_ok_out <= 1'b0;
    end else if (wait_done) begin
      dma_sop_out      <= 1'b1;
      dma_eop_out      <= hold_eop;
      dma_data_out     <= hold_data;
      dma_stamp_out    <= have_stamp ? stamp_sel : '0;
      dma_stamp_ok_out <= have_stamp;
    end else if (load_direct) begin
      dma_sop_out      <= pkt_sop_in;
      dma_eop_out      <= pkt_eop_in;
      dma_data_out     <= pkt_data_in;
      dma_stamp_out    <= '0;
      dma_stamp_ok_out <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hold_data  <= '0;
      hold_eop   <= 1'b0;
      stamp_got  <= 1'b0;
      stamp_hold <= '0;
      wait_cnt   <= '0;
    end else if (sop_take && host_stamp_en_in && state != rits_pkg::RITS_WAIT) begin
      hold_data  <= pkt_data_in;
      hold_eop   <= pkt_eop_in;
      stamp_got  <= 1'b0;
      wait_cnt   <= '0;
    end else if (state == rits_pkg::RITS_WAIT) begin
      if (stamp_now && !stamp_got) begin
        stamp_got  <= 1'b1;
        stamp_hold <= ts.stamp;
      end
      if (!timed_out) begin
        wait_cnt <= wait_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      word_idx <= '0;
      sop_time <= '0;
    end else if (accept) begin
      if (cur_idx != '1) begin
        word_idx <= cur_idx + 1'b1;
      end else begin
        word_idx <= cur_idx;
      end
      if (pkt_sop_in) begin
        sop_time <= ts.time_now;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_ptr           <= '0;
      rd_ptr           <= '0;
      evt_count        <= '0;
      evt_valid_out    <= 1'b0;
      evt_stamp_out    <= '0;
      evt_overflow_out <= 1'b0;
      for (int i = 0; i < EVT_DEPTH; i++) begin
        evt_mem[i] <= '0;
      end
    end else begin
      if (evt_push) begin
        evt_mem[wr_ptr] <= evt_time;
        wr_ptr          <= PTR_W'(wr_ptr + 1'b1);
      end
      rd_ptr           <= next_rd_ptr;
      evt_count        <= next_evt_count;
      evt_valid_out    <= (next_evt_count != '0);
      evt_stamp_out    <= next_evt_head;
      evt_overflow_out <= evt_drop;
    end
  end
endmodule : rits_rx_ingress_ts
`default_nettype wire

// ---- test/rits_rx_ingress_ts_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module rits_rx_ingress_ts_chk #(
  parameter int WAIT_CYCLES = rits_pkg::STAMP_WAIT_CYCLES,
  parameter int EVT_DEPTH   = rits_pkg::EVT_DEPTH
) (
  input wire logic        clock_in,
  input wire logic        rst_b_in,
  input wire logic        host_stamp_en_in,
  input wire logic        evt_en_in,
  input wire logic [15:0] evt_ethertype_in,
  input wire logic        pkt_valid_in,
  input wire logic        pkt_sop_in,
  input wire logic [31:0] pkt_data_in,
  input wire logic        pkt_preamble_ok_in,
  input wire logic        pkt_ready_out,
  input wire logic        dma_valid_out,
  input wire logic        dma_sop_out,
  input wire logic [31:0] dma_data_out,
  input wire logic        dma_stamp_ok_out,
  input wire logic        dma_ready_in,
  input wire logic        evt_valid_out
);
  localparam int TO_HI = WAIT_CYCLES + 4;
  logic [2:0] idx;
  wire        take = pkt_valid_in & pkt_ready_out;
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) idx <= 3'h0;
    else if (take) idx <= pkt_sop_in ? 3'h1 : (idx == 3'h7 ? idx : idx + 3'h1);
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_host_take;
    take && pkt_sop_in && host_stamp_en_in;
  endsequence
  sequence s_stamped_out;
    !dma_valid_out [*2] ##1 (dma_valid_out && dma_sop_out && dma_stamp_ok_out);
  endsequence
  chk_host_stamp: assert property (s_host_take and pkt_preamble_ok_in |=> s_stamped_out)
    else $error("stamped start word not on time");
  chk_timeout_mark: assert property (s_host_take and !pkt_preamble_ok_in |=> !dma_valid_out [*3]
    ##[1:TO_HI] (dma_valid_out && dma_sop_out && !dma_stamp_ok_out))
    else $error("unstamped start word missing");
  chk_plain_pass: assert property (take && pkt_sop_in && !host_stamp_en_in |=>
    dma_valid_out && dma_sop_out && !dma_stamp_ok_out)
    else $error("plain start word late");
  chk_dma_hold: assert property (dma_valid_out && !dma_ready_in |=>
    dma_valid_out && $stable(dma_data_out))
    else $error("dma word not held");
  chk_ready_drop: assert property (take |=> !pkt_ready_out)
    else $error("ready stayed high after take");
  chk_ready_block: assert property (dma_valid_out |-> !pkt_ready_out)
    else $error("ready high with word pending");
  chk_ready_back: assert property (dma_valid_out && dma_ready_in |=> pkt_ready_out)
    else $error("ingress stalled after dma take");
  chk_evt_push: assert property (take && !pkt_sop_in && idx == rits_pkg::ETYPE_WORD_IDX && evt_en_in
    && pkt_data_in[31:16] == evt_ethertype_in |=> evt_valid_out)
    else $error("event stamp not queued");
endmodule : rits_rx_ingress_ts_chk
bind rits_rx_ingress_ts rits_rx_ingress_ts_chk #(.WAIT_CYCLES(WAIT_CYCLES), .EVT_DEPTH(EVT_DEPTH))
  u_chk (.clock_in, .rst_b_in, .host_stamp_en_in, .evt_en_in, .evt_ethertype_in, .pkt_valid_in,
  .pkt_sop_in, .pkt_data_in, .pkt_preamble_ok_in, .pkt_ready_out, .dma_valid_out, .dma_sop_out,
  .dma_data_out, .dma_stamp_ok_out, .dma_ready_in, .evt_valid_out);
`default_nettype wire

// ---- test/rits_dma_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module rits_dma_host_model (
  // Clock, reset and pacing
  input  wire logic        clock_in,
  input  wire logic        rst_b_in,
  input  wire logic        stall_in,
  input  wire logic        pop_en_in,
  // Block outputs
  input  wire logic        dma_valid_in,
  input  wire logic        dma_sop_in,
  input  wire logic        dma_stamp_ok_in,
  input  wire logic [31:0] dma_data_in,
  input  wire logic [31:0] dma_stamp_in,
  input  wire logic        evt_valid_in,
  // Answers and tallies
  output var  logic        dma_ready_out,
  output var  logic        evt_pop_out,
  output var  logic        sop_ok_out,
  output var  logic [7:0]  n_words_out,
  output var  logic [7:0]  n_pops_out,
  output var  logic [31:0] sop_stamp_out
);
  assign dma_ready_out = !stall_in;
  // Event stamps are fetched on their own, apart from the payload.
  assign evt_pop_out = evt_valid_in & pop_en_in;
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      n_words_out <= 8'h00;
      n_pops_out <= 8'h00;
      sop_ok_out <= 1'b0;
      sop_stamp_out <= 32'h0000_0000;
    end else begin
      if (evt_pop_out) n_pops_out <= n_pops_out + 8'h01;
      if (dma_valid_in && dma_ready_out) begin
        n_words_out <= n_words_out + 8'h01;
        if (dma_sop_in) begin
          sop_ok_out <= dma_stamp_ok_in;
          sop_stamp_out <= dma_stamp_in;
        end
      end
    end
  end
endmodule : rits_dma_host_model
`default_nettype wire

// ---- test/tb_rx_ingress_timestamp_path.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_rx_ingress_timestamp_path;
  logic clock_in, rst_b_in, host_stamp_en_in, evt_en_in, pkt_valid_in, pkt_sop_in, pkt_eop_in;
  logic pkt_preamble_ok_in, pkt_ready_out, dma_valid_out, dma_sop_out, dma_eop_out;
  logic dma_stamp_ok_out, dma_ready_in, evt_valid_out, evt_pop_in, evt_overflow_out;
  logic stall, pop_en, ovf_seen, sop_ok;
  logic [15:0] evt_ethertype_in;
  logic [31:0] pkt_data_in, dma_data_out, dma_stamp_out, evt_stamp_out, sop_stamp;
  logic [7:0] n_words, n_pops;
  int n_fail = 0, checks = 0, cyc = 0, take_cyc = 0, rel_cyc = 0;
  rits_rx_ingress_ts #(.WAIT_CYCLES(8), .EVT_DEPTH(4)) dut (.*);
  rits_dma_host_model u_host (.clock_in, .rst_b_in, .stall_in(stall), .pop_en_in(pop_en),
    .dma_valid_in(dma_valid_out), .dma_sop_in(dma_sop_out), .dma_stamp_ok_in(dma_stamp_ok_out),
    .dma_data_in(dma_data_out), .dma_stamp_in(dma_stamp_out), .evt_valid_in(evt_valid_out),
    .dma_ready_out(dma_ready_in), .evt_pop_out(evt_pop_in), .sop_ok_out(sop_ok),
    .n_words_out(n_words), .n_pops_out(n_pops), .sop_stamp_out(sop_stamp));
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (!rst_b_in) ovf_seen <= 1'b0;
    else if (evt_overflow_out === 1'b1) ovf_seen <= 1'b1;
  end
  task automatic wrap_up;
    if (n_fail == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask : cmp
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : tick
  task automatic send(input logic s, input logic e, input logic p, input logic [31:0] d);
    int i = 0;
    while (pkt_ready_out !== 1'b1 && i < 60) begin
      tick(1);
      i++;
    end
    if (pkt_ready_out !== 1'b1) begin
      n_fail++;
      wrap_up();
    end
    {pkt_valid_in, pkt_sop_in, pkt_eop_in, pkt_preamble_ok_in, pkt_data_in} = {1'b1, s, e, p, d};
    if (s) take_cyc = cyc;
    tick(1);
    pkt_valid_in = 1'b0;
  endtask : send
  task automatic send_pkt(input int n, input logic p, input logic [15:0] ety);
    for (int k = 0; k < n; k++) begin
      send(k == 0, k == n - 1, p, k == 3 ? {ety, 16'h0000} : k);
    end
    tick(1);
  endtask : send_pkt
  task automatic wait_for(input logic pops, input logic [7:0] tgt);
    int i = 0;
    while ((pops ? n_pops : n_words) !== tgt && i < 60) begin
      tick(1);
      i++;
    end
    cmp(pops ? "pops" : "words", tgt, pops ? n_pops : n_words);
    if (i == 60) wrap_up();
  endtask : wait_for
  task automatic sc_plain;
    host_stamp_en_in = 1'b0;
    stall = 1'b1;
    cmp("ready after reset", 32'h1, pkt_ready_out);
    send(1'b1, 1'b0, 1'b1, 32'h0000_00A5);
    tick(5);
    cmp("held valid", 32'h1, dma_valid_out);
    cmp("held data", 32'h0000_00A5, dma_data_out);
    cmp("held eop", 32'h0, dma_eop_out);
    cmp("held ready", 32'h0, pkt_ready_out);
    stall = 1'b0;
    send_pkt(3, 1'b1, 16'h0800);
    wait_for(1'b0, 8'h04);
    cmp("plain ok", 32'h0, sop_ok);
  endtask : sc_plain
  task automatic sc_host;
    int t0;
    logic [31:0] s0;
    host_stamp_en_in = 1'b1;
    send_pkt(1, 1'b1, 16'h0800);
    t0 = take_cyc;
    wait_for(1'b0, 8'h05);
    cmp("stamp ok", 32'h1, sop_ok);
    cmp("stamp value", t0 - rel_cyc, sop_stamp);
    s0 = sop_stamp;
    send_pkt(2, 1'b1, 16'h0800);
    wait_for(1'b0, 8'h07);
    cmp("stamp gap", take_cyc - t0, sop_stamp - s0);
  endtask : sc_host
  task automatic sc_timeout;
    send_pkt(2, 1'b0, 16'h0800);
    wait_for(1'b0, 8'h09);
    cmp("unstamped", 32'h0, sop_ok);
    cmp("unstamped value", 32'h0, sop_stamp);
    send_pkt(1, 1'b1, 16'h0800);
    wait_for(1'b0, 8'h0A);
    cmp("recovered", 32'h1, sop_ok);
  endtask : sc_timeout
  task automatic sc_event;
    int t0;
    host_stamp_en_in = 1'b0;
    evt_en_in = 1'b1;
    send_pkt(4, 1'b1, 16'h88F7);
    t0 = take_cyc;
    repeat (4) send_pkt(4, 1'b1, 16'h88F7);
    cmp("overflow", 32'h1, ovf_seen);
    cmp("evt head", t0 - rel_cyc, evt_stamp_out);
    pop_en = 1'b1;
    wait_for(1'b1, 8'h04);
    send_pkt(4, 1'b1, 16'h0800);
    send_pkt(4, 1'b1, 16'h88F7);
    tick(4);
    cmp("pops", 32'h5, n_pops);
  endtask : sc_event
  initial begin
    {rst_b_in, host_stamp_en_in, evt_en_in, pkt_valid_in, pkt_sop_in, pkt_eop_in} = 6'h00;
    {pkt_preamble_ok_in, stall, pop_en, pkt_data_in} = 35'h0;
    evt_ethertype_in = 16'h88F7;
    repeat (20) @(posedge clock_in);
    #1 rst_b_in = 1'b1;
    rel_cyc = cyc;
    tick(2);
    sc_plain();
    sc_host();
    sc_timeout();
    sc_event();
    wrap_up();
  end
endmodule : tb_rx_ingress_timestamp_path
`default_nettype wire
